// ==== core/uesi_regs.svh ====
/*
  Register offsets, bit positions and reset values of the endpoint status block
  and of its controller. Assumes inclusion by bare name from core/.
*/
`ifndef UESI_REGS_SVH
`define UESI_REGS_SVH

// ---------------------------------------------------------------
// Device register offsets
// ---------------------------------------------------------------
`define UESI_SELECT_ADDR 8'hc7
`define UESI_IRQ_EN_ADDR 8'hc2
`define UESI_STATUS_ADDR 8'hce
`define UESI_FIFO_RST_ADDR 8'hd5
`define UESI_IRQ_FLAGS_ADDR 8'hf8

// ---------------------------------------------------------------
// Status register bit positions
// ---------------------------------------------------------------
`define UESI_ST_STALL_REQ 5
`define UESI_ST_IN_READY 4
`define UESI_ST_STALL_SENT_OR_CRC_ERROR 3
`define UESI_ST_SETUP 2
`define UESI_ST_OUTB0 1
`define UESI_ST_IN_DONE 0
`define UESI_ST_MASK 8'h3f

// ---------------------------------------------------------------
// Common values
// ---------------------------------------------------------------
`define UESI_EP_MASK 8'h07
`define UESI_REG_RESET 8'h00
`define UESI_TYPE_ISO 2'h1
`define UESI_NUM_EP 3

// ---------------------------------------------------------------
// Controller register offsets (software side)
// ---------------------------------------------------------------
`define UESI_H_ADDR 3'h0
`define UESI_H_WRITE 3'h1
`define UESI_H_READ 3'h2
`define UESI_H_RDATA 3'h3
`define UESI_H_STAT 3'h4
`define UESI_H_MASK 3'h5
`define UESI_H_BUSY 3'h6

// Controller event bits
`define UESI_EV_RD_DONE 0
`define UESI_EV_REFUSED 1
`define UESI_EV_DEV_IRQ 2
`define UESI_EV_DROPPED 3

`endif

// ==== core/uesi_pkg.sv ====
/*
  Types shared by both ends of the endpoint status block.
  Assumes uesi_regs.svh for the numeric constants.
*/
package uesi_pkg;

  // Controller sequencer states, one-hot
  typedef enum logic [3:0] {
    UESI_IDLE = 4'b0001,
    UESI_RWAIT = 4'b0010,
    UESI_RDATA = 4'b0100,
    UESI_CLEAR = 4'b1000
  } uesi_hstate_t;

  // Whole state of the device end
  typedef struct packed {
    logic [1:0] select;
    logic [2:0][7:0] status;
    logic [2:0] fifo_rst;
    logic [2:0] irq_flags;
    logic [2:0] irq_en;
    logic [7:0] rdata;
    logic irq;
    logic [2:0] stall;
    logic [2:0] ready;
    logic [2:0] zlp;
    logic [2:0] nak;
  } uesi_dev_state_t;

  // Whole state of the controller end
  typedef struct packed {
    uesi_hstate_t state;
    logic [7:0] dev_addr;
    logic [7:0] pend_data;
    logic pend_wr;
    logic [7:0] rdata;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [7:0] sw_rdata;
    logic irq;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
  } uesi_host_state_t;

endpackage

// ==== core/uesi_if.sv ====
/*
  Register link between the endpoint status block and its controller.
  Assumes both ends share one clock; the bench joins the two modports.
*/
`timescale 1ns/1ps
interface uesi_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;

  modport dev (input addr, input wdata, input wr, input rd, output rdata, output irq);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface

// ==== core/uesi_dev.sv ====
/*
  Endpoint status, handshake control and interrupt flags for three endpoints.
  Assumes transaction events from the serial engine on the same clock, one
  event group per cycle for the endpoint on ev_ep_in, and a controller on the
  register link that keeps the firmware obligations.
*/
// Notes on behaviour
// - Stall request forces STALL on next handshake
// - Firmware loads IN data only while ready clear
// - Ready with empty FIFO sends zero-length packet
// - Ready cleared on send (iso) or ACK
// - Stall sent sets flag; SETUP clears it
// - Iso: flag marks CRC error, cleared by good data
// - SETUP sets flag, clears all other status bits
// - Firmware clears setup flag after reading data
// - Bank 0 flag set; NAK until cleared, not iso
// - Early SETUP may overwrite unread bank 0
// - Firmware clears bank 0 flag after reading
// - IN complete set on send (iso) or ACK
// - Firmware clears IN complete before next ready
// - FIFO reset bits 0..2, set then clear
// - Reserved bits 7..3 read zero, never written
// - Endpoint flag set on enabled event, software clears
// - Status acts on the selected endpoint
// - Enable bits 0..2 gate endpoint flags
`timescale 1ns/1ps
`include "uesi_regs.svh"
module uesi_dev (
  input wire logic clk_in,
  input wire logic reset_in,
  uesi_if.dev bus,
  input wire logic [1:0] ev_ep_in,
  input wire logic ev_setup_in,
  input wire logic ev_out_stored_in,
  input wire logic ev_out_crc_err_in,
  input wire logic ev_in_sent_in,
  input wire logic ev_in_acked_in,
  input wire logic ev_stall_sent_in,
  input wire logic [5:0] ep_types_in,
  input wire logic [2:0] fifo_empty_in,
  output logic [2:0] stall_out,
  output logic [2:0] in_ready_out,
  output logic [2:0] zlp_out,
  output logic [2:0] out_nak_out,
  output logic [2:0] fifo_reset_out
);
  import uesi_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Isochronous type check, used for every endpoint
  function automatic logic is_iso(input logic [5:0] types, input int ep);
    logic [1:0] t;
    t = types[ep*2 +: 2];
    return t == `UESI_TYPE_ISO;
  endfunction

  // Event addressed to endpoint ep
  function automatic logic ep_hit(input logic [1:0] sel, input int ep);
    return sel == ep[1:0];
  endfunction

  // Status byte of the selected endpoint; index 3 reads as zero
  function automatic logic [7:0] sel_status(input uesi_dev_state_t st);
    logic [7:0] v;
    v = 8'h00;
    if (st.select < 2'd3) begin
      v = st.status[st.select] & `UESI_ST_MASK;
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  uesi_dev_state_t s_ff;
  uesi_dev_state_t nxt_s;
  logic [2:0] trig;
  logic iso;

  // Next-state logic: register access first, then hardware events so
  // that a set arriving with a software clear is never lost
  always_comb begin
    nxt_s = s_ff;
    trig = 3'h0;
    iso = 1'b0;
    nxt_s.rdata = 8'h00;

    // Read answer, valid only in the cycle after the strobe
    if (bus.rd) begin
      case (bus.addr)
        `UESI_SELECT_ADDR: begin
          nxt_s.rdata = {6'h00, s_ff.select};
        end
        `UESI_STATUS_ADDR: begin
          nxt_s.rdata = sel_status(s_ff);
        end
        `UESI_FIFO_RST_ADDR: begin
          nxt_s.rdata = {5'h00, s_ff.fifo_rst};
        end
        `UESI_IRQ_FLAGS_ADDR: begin
          nxt_s.rdata = {5'h00, s_ff.irq_flags};
        end
        `UESI_IRQ_EN_ADDR: begin
          nxt_s.rdata = {5'h00, s_ff.irq_en};
        end
        default: begin
          nxt_s.rdata = 8'h00;
        end
      endcase
    end

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        `UESI_SELECT_ADDR: begin
          nxt_s.select = bus.wdata[1:0];
        end
        `UESI_STATUS_ADDR: begin
          // Writes to endpoint index 3 land nowhere
          if (s_ff.select < 2'd3) begin
            nxt_s.status[s_ff.select] = bus.wdata & `UESI_ST_MASK;
          end
        end
        `UESI_FIFO_RST_ADDR: begin
          nxt_s.fifo_rst = bus.wdata[2:0];
        end
        `UESI_IRQ_FLAGS_ADDR: begin
          // Writing zero clears a flag, writing one keeps it
          nxt_s.irq_flags = s_ff.irq_flags & bus.wdata[2:0];
        end
        `UESI_IRQ_EN_ADDR: begin
          nxt_s.irq_en = bus.wdata[2:0];
        end
        default: begin
          nxt_s.select = s_ff.select;
        end
      endcase
    end

    // Transaction events per endpoint
    for (int e = 0; e < `UESI_NUM_EP; e++) begin
      iso = is_iso(ep_types_in, e);
      if (ep_hit(ev_ep_in, e)) begin
        if (ev_setup_in) begin
          // Accepted even while bank 0 is full on a control endpoint
          nxt_s.status[e] = 8'h00;
          nxt_s.status[e][`UESI_ST_SETUP] = 1'b1;
          trig[e] = 1'b1;
        end else begin
          if (iso ? ev_in_sent_in : ev_in_acked_in) begin
            nxt_s.status[e][`UESI_ST_IN_READY] = 1'b0;
            nxt_s.status[e][`UESI_ST_IN_DONE] = 1'b1;
            trig[e] = 1'b1;
          end
          if (ev_out_stored_in) begin
            nxt_s.status[e][`UESI_ST_OUTB0] = 1'b1;
            trig[e] = 1'b1;
            if (iso) begin
              nxt_s.status[e][`UESI_ST_STALL_SENT_OR_CRC_ERROR] = 1'b0;
            end
          end
          if (iso && ev_out_crc_err_in) begin
            nxt_s.status[e][`UESI_ST_STALL_SENT_OR_CRC_ERROR] = 1'b1;
            trig[e] = 1'b1;
          end
          if (!iso && ev_stall_sent_in && s_ff.status[e][`UESI_ST_STALL_REQ]) begin
            nxt_s.status[e][`UESI_ST_STALL_SENT_OR_CRC_ERROR] = 1'b1;
            trig[e] = 1'b1;
          end
        end
      end
    end

    // Flags set after the clear so the event wins
    nxt_s.irq_flags = nxt_s.irq_flags | (trig & s_ff.irq_en);
    nxt_s.irq = |nxt_s.irq_flags;

    // Handshake steering, registered so outputs come from flops
    for (int e = 0; e < `UESI_NUM_EP; e++) begin
      iso = is_iso(ep_types_in, e);
      nxt_s.stall[e] = nxt_s.status[e][`UESI_ST_STALL_REQ];
      nxt_s.ready[e] = nxt_s.status[e][`UESI_ST_IN_READY];
      // Ready with nothing loaded means a zero-length packet
      nxt_s.zlp[e] = nxt_s.status[e][`UESI_ST_IN_READY] & fifo_empty_in[e];
      nxt_s.nak[e] = nxt_s.status[e][`UESI_ST_OUTB0] & ~iso;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------

  // Synchronous reset to all zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Straight from the state flops
  assign bus.rdata = s_ff.rdata;
  assign bus.irq = s_ff.irq;
  assign stall_out = s_ff.stall;
  assign in_ready_out = s_ff.ready;
  assign zlp_out = s_ff.zlp;
  assign out_nak_out = s_ff.nak;
  assign fifo_reset_out = s_ff.fifo_rst;

endmodule

// ==== core/uesi_host.sv ====
/*
  Controller end: takes orders from software over a plain register port and
  performs them on the endpoint status block, keeping the firmware duties.
  Assumes one clock shared with the device end.
*/
`timescale 1ns/1ps
`include "uesi_regs.svh"
module uesi_host (
  input wire logic clk_in,
  input wire logic reset_in,
  uesi_if.host bus,
  input wire logic [2:0] sw_addr_in,
  input wire logic [7:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [7:0] sw_rdata_out,
  output logic irq_out
);
  import uesi_pkg::*;

  uesi_host_state_t s_ff;
  uesi_host_state_t nxt_s;
  logic [3:0] ev;
  logic busy;

  // ---------------------------------------------------------------
  // Sequencer and software registers
  // ---------------------------------------------------------------

  // One order at a time; orders while busy are dropped and flagged
  always_comb begin
    nxt_s = s_ff;
    ev = 4'h0;
    busy = s_ff.state != UESI_IDLE;
    nxt_s.bus_wr = 1'b0;
    nxt_s.bus_rd = 1'b0;
    nxt_s.sw_rdata = 8'h00;
    if (bus.irq) begin
      ev[`UESI_EV_DEV_IRQ] = 1'b1;
    end
    case (s_ff.state)
      UESI_IDLE: begin
        nxt_s.pend_wr = 1'b0;
      end
      UESI_RWAIT: begin
        nxt_s.state = UESI_RDATA;
      end
      UESI_RDATA: begin
        nxt_s.state = UESI_IDLE;
        if (s_ff.pend_wr) begin
          // Ready only when IN ready and IN complete are both clear
          if (bus.rdata[`UESI_ST_IN_READY] || bus.rdata[`UESI_ST_IN_DONE]) begin
            ev[`UESI_EV_REFUSED] = 1'b1;
          end else begin
            nxt_s.bus_wr = 1'b1;
            nxt_s.bus_addr = s_ff.dev_addr;
            nxt_s.bus_wdata = s_ff.pend_data;
          end
        end else begin
          nxt_s.rdata = bus.rdata;
          ev[`UESI_EV_RD_DONE] = 1'b1;
        end
      end
      UESI_CLEAR: begin
        // Second half of the FIFO reset pulse
        nxt_s.state = UESI_IDLE;
        nxt_s.bus_wr = 1'b1;
        nxt_s.bus_addr = `UESI_FIFO_RST_ADDR;
        nxt_s.bus_wdata = `UESI_REG_RESET;
      end
      default: begin
        nxt_s.state = UESI_IDLE;
      end
    endcase

    if (sw_wr_in) begin
      case (sw_addr_in)
        `UESI_H_ADDR: begin
          nxt_s.dev_addr = sw_wdata_in;
        end
        `UESI_H_MASK: begin
          nxt_s.mask = sw_wdata_in[3:0];
        end
        `UESI_H_WRITE, `UESI_H_READ: begin
          if (busy) begin
            ev[`UESI_EV_DROPPED] = 1'b1;
          end else if (sw_addr_in == `UESI_H_READ) begin
            nxt_s.bus_rd = 1'b1;
            nxt_s.bus_addr = s_ff.dev_addr;
            nxt_s.state = UESI_RWAIT;
          end else if (s_ff.dev_addr == `UESI_STATUS_ADDR &&
                       sw_wdata_in[`UESI_ST_IN_READY]) begin
            // Check the endpoint before marking a packet ready
            nxt_s.bus_rd = 1'b1;
            nxt_s.bus_addr = s_ff.dev_addr;
            nxt_s.pend_wr = 1'b1;
            nxt_s.pend_data = sw_wdata_in;
            nxt_s.state = UESI_RWAIT;
          end else begin
            nxt_s.bus_wr = 1'b1;
            nxt_s.bus_addr = s_ff.dev_addr;
            nxt_s.bus_wdata = sw_wdata_in;
            if (s_ff.dev_addr == `UESI_FIFO_RST_ADDR ||
                s_ff.dev_addr == `UESI_IRQ_FLAGS_ADDR) begin
              nxt_s.bus_wdata = sw_wdata_in & `UESI_EP_MASK;
            end
            if (s_ff.dev_addr == `UESI_FIFO_RST_ADDR) begin
              nxt_s.state = UESI_CLEAR;
            end
          end
        end
        default: begin
          nxt_s.mask = s_ff.mask;
        end
      endcase
    end

    // Software reads; status clears on read, a new event still wins
    if (sw_rd_in) begin
      case (sw_addr_in)
        `UESI_H_ADDR: nxt_s.sw_rdata = s_ff.dev_addr;
        `UESI_H_RDATA: nxt_s.sw_rdata = s_ff.rdata;
        `UESI_H_STAT: nxt_s.sw_rdata = {4'h0, s_ff.stat};
        `UESI_H_MASK: nxt_s.sw_rdata = {4'h0, s_ff.mask};
        `UESI_H_BUSY: nxt_s.sw_rdata = {7'h00, busy};
        default: nxt_s.sw_rdata = 8'h00;
      endcase
    end
    if (sw_rd_in && sw_addr_in == `UESI_H_STAT) begin
      nxt_s.stat = ev;
    end else begin
      nxt_s.stat = s_ff.stat | ev;
    end
    nxt_s.irq = |(nxt_s.stat & nxt_s.mask);
  end

  // Synchronous reset, sequencer back to idle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_ff <= '0;
      s_ff.state <= UESI_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state flops
  assign bus.addr = s_ff.bus_addr;
  assign bus.wdata = s_ff.bus_wdata;
  assign bus.wr = s_ff.bus_wr;
  assign bus.rd = s_ff.bus_rd;
  assign sw_rdata_out = s_ff.sw_rdata;
  assign irq_out = s_ff.irq;

endmodule

// ==== verif/uesi_assertions.sv ====
/*
  Checker on the register link between the two ends.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "uesi_regs.svh"
module uesi_assertions (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq
);
  // --------
  // Sequences
  // --------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Two steps of a FIFO reset, set then clear
  sequence rst_set; wr && addr == `UESI_FIFO_RST_ADDR && wdata != 8'h00; endsequence
  sequence rst_clr; wr && addr == `UESI_FIFO_RST_ADDR && wdata == 8'h00; endsequence
  sequence rd_of(logic [7:0] a); rd && addr == a; endsequence
  // A ready write is only made after a status read
  sequence ready_wr; wr && addr == `UESI_STATUS_ADDR && wdata[`UESI_ST_IN_READY]; endsequence

  // --------
  // Properties
  // --------
  a_rst_set_clear: assert property (rst_set |=> rst_clr)
    else $error("fifo reset left set");
  a_rst_no_reserved: assert property (wr && addr == `UESI_FIFO_RST_ADDR |-> wdata[7:3] == 5'h00)
    else $error("reserved fifo reset bits written");
  a_flag_no_reserved: assert property (wr && addr == `UESI_IRQ_FLAGS_ADDR |-> wdata[7:3] == 5'h00)
    else $error("reserved flag bits written");
  a_rst_reads_zero: assert property (rd_of(`UESI_FIFO_RST_ADDR) |=> rdata[7:3] == 5'h00)
    else $error("fifo reset reserved bits not zero");
  a_flag_reads_zero: assert property (rd_of(`UESI_IRQ_FLAGS_ADDR) |=> rdata[7:3] == 5'h00)
    else $error("flag reserved bits not zero");
  a_irq_any_flag: assert property (rd_of(`UESI_IRQ_FLAGS_ADDR) |=> (rdata[2:0] != 3'h0) == $past(irq))
    else $error("irq does not match flags");
  a_guard_ready: assert property (ready_wr |-> $past(rd, 2) && ($past(rdata) & 8'h11) == 8'h00)
    else $error("ready set without clear status");
  a_status_top: assert property (rd_of(`UESI_STATUS_ADDR) |=> rdata[7:6] == 2'h0)
    else $error("status top bits not zero");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read answer");
  a_one_strobe: assert property (!(wr && rd))
    else $error("write and read together");
endmodule

// ==== verif/usb_endpoint_status_irq_tb_top.sv ====
/*
  Bench: device and controller joined by the link; software port and
  event pulses driven here. Assumes core files and checker compiled first.
*/
`timescale 1ns/1ps
`include "uesi_regs.svh"
module usb_endpoint_status_irq_tb_top;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] sa = 3'h0;
  logic [7:0] sd = 8'h00;
  logic swr = 1'b0;
  logic srd = 1'b0;
  logic [1:0] ee = 2'h0;
  logic [5:0] ev = 6'h00;
  logic [5:0] ty = 6'h18; // ep2 isochronous, ep0 control, ep1 bulk
  logic [2:0] fe = 3'h5; // ep1 FIFO holds data
  logic [7:0] so;
  logic hirq;
  logic seen_rst = 1'b0;
  logic [2:0] stl, rdy, zlp, nak, frs;
  int fails = 0;
  int num_checks = 0;

  // --------
  // Clock, ends and checker
  // --------
  always #2.5 clk_in = ~clk_in;
  uesi_if link ();
  uesi_dev uesi_dev_i (.clk_in(clk_in), .reset_in(reset_in), .bus(link), .ev_ep_in(ee),
    .ev_setup_in(ev[0]), .ev_out_stored_in(ev[1]), .ev_out_crc_err_in(ev[2]),
    .ev_in_sent_in(ev[3]), .ev_in_acked_in(ev[4]), .ev_stall_sent_in(ev[5]),
    .ep_types_in(ty), .fifo_empty_in(fe), .stall_out(stl), .in_ready_out(rdy),
    .zlp_out(zlp), .out_nak_out(nak), .fifo_reset_out(frs));
  uesi_host uesi_host_i (.clk_in(clk_in), .reset_in(reset_in), .bus(link), .sw_addr_in(sa),
    .sw_wdata_in(sd), .sw_wr_in(swr), .sw_rd_in(srd), .sw_rdata_out(so), .irq_out(hirq));
  uesi_assertions uesi_assertions_i (.clk_in(clk_in), .reset_in(reset_in), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .irq(link.irq));
  // Reset pulse is too short to poll, so latch it
  always @(posedge clk_in) if (frs === 3'h7) seen_rst <= 1'b1;

  // --------
  // Helpers
  // --------
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask
  // Software port; a spare edge keeps strobes from being set twice at once
  task automatic sw(input logic [2:0] a, input logic [7:0] d);
    sa <= a;
    sd <= d;
    swr <= 1'b1;
    @(posedge clk_in);
    swr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic sr(input logic [2:0] a, output logic [7:0] d);
    sa <= a;
    srd <= 1'b1;
    @(posedge clk_in);
    srd <= 1'b0;
    #1;
    d = so;
    @(posedge clk_in);
  endtask
  task automatic idle;
    logic [7:0] b;
    for (int i = 0; i < 20; i++) begin
      sr(`UESI_H_BUSY, b);
      if (b[0] === 1'b0) return;
    end
    chk("busy", b, 8'h00);
  endtask
  task automatic dw(input logic [7:0] a, input logic [7:0] d);
    sw(`UESI_H_ADDR, a);
    sw(`UESI_H_WRITE, d);
    idle();
  endtask
  task automatic dr(input logic [7:0] a, output logic [7:0] d);
    sw(`UESI_H_ADDR, a);
    sw(`UESI_H_READ, 8'h00);
    idle();
    sr(`UESI_H_RDATA, d);
  endtask
  task automatic cs(input logic [1:0] e, input logic [7:0] x);
    logic [7:0] d;
    dw(`UESI_SELECT_ADDR, {6'h00, e});
    dr(`UESI_STATUS_ADDR, d);
    chk("status", d, x);
  endtask
  task automatic cf(input logic [7:0] x);
    logic [7:0] d;
    dr(`UESI_IRQ_FLAGS_ADDR, d);
    chk("flags", d, x);
  endtask
  // Event k: 0 setup, 1 out stored, 2 crc error, 3 in sent, 4 acked, 5 stall
  task automatic pulse(input logic [1:0] e, input int k);
    ee <= e;
    ev <= 6'h01 << k;
    @(posedge clk_in);
    ev <= 6'h00;
    @(posedge clk_in);
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_fifo;
    logic [7:0] d;
    dw(`UESI_FIFO_RST_ADDR, 8'hff);
    chk("fifo reset seen", {7'h00, seen_rst}, 8'h01);
    dr(`UESI_FIFO_RST_ADDR, d);
    chk("fifo reset reg", d, 8'h00);
    cf(8'h00);
    $display("test fifo done");
  endtask
  task automatic t_setup;
    logic [7:0] d;
    sw(`UESI_H_MASK, 8'h04);
    dw(`UESI_IRQ_EN_ADDR, 8'h07);
    dw(`UESI_SELECT_ADDR, 8'h00);
    dw(`UESI_STATUS_ADDR, 8'h30);
    @(negedge clk_in);
    chk("stall", {5'h00, stl}, 8'h01);
    chk("zlp", {5'h00, zlp}, 8'h01);
    @(posedge clk_in);
    pulse(2'd0, 0);
    @(negedge clk_in);
    chk("stall", {5'h00, stl}, 8'h00);
    chk("irq", {7'h00, hirq}, 8'h01);
    @(posedge clk_in);
    cs(2'd0, 8'h04);
    cf(8'h01);
    dw(`UESI_IRQ_FLAGS_ADDR, 8'h00);
    dw(`UESI_STATUS_ADDR, 8'h00);
    sr(`UESI_H_STAT, d);
    @(negedge clk_in);
    chk("irq", {7'h00, hirq}, 8'h00);
    @(posedge clk_in);
    $display("test setup done");
  endtask
  task automatic t_in;
    logic [7:0] d;
    dw(`UESI_SELECT_ADDR, 8'h01);
    dw(`UESI_STATUS_ADDR, 8'h10);
    @(negedge clk_in);
    chk("ready", {5'h00, rdy}, 8'h02);
    chk("zlp", {5'h00, zlp}, 8'h00);
    @(posedge clk_in);
    pulse(2'd1, 3);
    cs(2'd1, 8'h10);
    pulse(2'd1, 4);
    cs(2'd1, 8'h01);
    cf(8'h02);
    dw(`UESI_STATUS_ADDR, 8'h10);
    cs(2'd1, 8'h01);
    // The refused ready write must leave its trace in the event status
    sr(`UESI_H_STAT, d);
    chk("refused", {7'h00, d[`UESI_EV_REFUSED]}, 8'h01);
    // Isochronous endpoint: ready drops on transmission alone
    dw(`UESI_SELECT_ADDR, 8'h02);
    dw(`UESI_STATUS_ADDR, 8'h10);
    @(negedge clk_in);
    chk("ready", {5'h00, rdy}, 8'h04);
    @(posedge clk_in);
    pulse(2'd2, 3);
    cs(2'd2, 8'h01);
    dw(`UESI_IRQ_FLAGS_ADDR, 8'h00);
    $display("test in done");
  endtask
  task automatic t_out;
    pulse(2'd1, 1);
    cs(2'd1, 8'h03);
    pulse(2'd2, 1);
    cs(2'd2, 8'h03);
    @(negedge clk_in);
    chk("nak", {5'h00, nak}, 8'h02);
    @(posedge clk_in);
    pulse(2'd2, 2);
    cs(2'd2, 8'h0b);
    pulse(2'd2, 1);
    cs(2'd2, 8'h03);
    pulse(2'd0, 1);
    pulse(2'd0, 0);
    cs(2'd0, 8'h04);
    // Firmware empties bank 0 of ep1, so NAK must lift
    dw(`UESI_SELECT_ADDR, 8'h01);
    dw(`UESI_STATUS_ADDR, 8'h00);
    @(negedge clk_in);
    chk("nak", {5'h00, nak}, 8'h00);
    @(posedge clk_in);
    dw(`UESI_IRQ_FLAGS_ADDR, 8'h00);
    $display("test out done");
  endtask
  task automatic t_stall;
    logic [7:0] d;
    dw(`UESI_IRQ_EN_ADDR, 8'h05);
    dw(`UESI_SELECT_ADDR, 8'h01);
    dw(`UESI_STATUS_ADDR, 8'h20);
    pulse(2'd1, 5);
    cs(2'd1, 8'h28);
    cf(8'h00);
    pulse(2'd1, 0);
    cs(2'd1, 8'h04);
    cs(2'd3, 8'h00);
    dr(8'h00, d);
    chk("unmapped", d, 8'h00);
    $display("test stall done");
  endtask

  // --------
  // Run and verdict
  // --------
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    t_fifo();
    t_setup();
    t_in();
    t_out();
    t_stall();
    stop_test();
  end
  // Watchdog far beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    stop_test();
  end
endmodule
